// ### rtl/ilo_pkg.sv
package ilo_pkg;

    // Data memory geometry
    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 8;
    localparam int          INSN_W        = 16;

    // Indexed window: access-bank operands up to this value are offsets
    localparam logic [7:0]  OFFSET_MAX    = 8'h5F;
    localparam logic [7:0]  ALL_ONES      = 8'hFF;
    localparam logic [11:0] PTR_RESET     = 12'h000;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;
    localparam logic [11:0] ACCESS_HI_BASE = 12'hF00;

    // Opcode fields
    localparam logic [5:0]  OPC_ADD       = 6'h09;   // 0010 01
    localparam logic [3:0]  OPC_BITSET    = 4'h8;    // 1000
    localparam logic [7:0]  OPC_SETALL    = 8'h68;   // 0110 1000
    localparam int          ADD_OPC_LSB   = 10;
    localparam int          BIT_OPC_LSB   = 12;
    localparam int          DEST_BIT      = 9;
    localparam int          ACCESS_BIT    = 8;
    localparam int          BITPOS_LSB    = 9;

    // Operation kinds
    typedef enum logic [1:0] {
        OP_NONE   = 2'b00,
        OP_ADD    = 2'b01,
        OP_BITSET = 2'b10,
        OP_SETALL = 2'b11
    } op_t;

    // Per-instruction phases, Gray coded
    typedef enum logic [1:0] {
        PH_DECODE  = 2'b00,
        PH_READ    = 2'b01,
        PH_PROCESS = 2'b11,
        PH_WRITE   = 2'b10
    } phase_t;

    // Decoded instruction
    typedef struct packed {
        op_t         op;
        logic        to_file;
        logic [2:0]  bitpos;
        logic [11:0] addr;
    } decoded_t;

    // Status flags
    typedef struct packed {
        logic neg;
        logic ovf;
        logic zero;
        logic dcarry;
        logic carry;
    } flags_t;

    // Data memory request
    typedef struct packed {
        logic        we;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } mem_req_t;

endpackage

// ### rtl/ilo_decode.sv
`timescale 1ns/1ps

// Decodes one instruction word into an indexed operation and its address.
module ilo_decode (
    input  wire logic [15:0]      insn,
    input  wire logic             ext_en,
    input  wire logic [11:0]      frame_ptr,
    input  wire logic [3:0]       bank_sel,
    output ilo_pkg::decoded_t     dec
);
    import ilo_pkg::*;

    logic [7:0] operand;    // Low byte: file address or offset
    logic       indexed;    // Operand reinterpreted as offset

    // Pattern match and address formation
    always_comb begin
        operand     = insn[7:0];
        dec.op      = OP_NONE;
        dec.to_file = insn[DEST_BIT];
        dec.bitpos  = insn[BITPOS_LSB +: 3];
        // Only extended mode, access bit clear and offset in window
        indexed = ext_en && !insn[ACCESS_BIT] && (operand <= OFFSET_MAX);
        if (insn[INSN_W-1 -: 6] == OPC_ADD) begin
            dec.op = OP_ADD;
        end else if (insn[INSN_W-1 -: 4] == OPC_BITSET) begin
            dec.op      = OP_BITSET;
            // Bit position overlays the add's destination bit; always memory
            dec.to_file = 1'b1;
        end else if (insn[INSN_W-1 -: 8] == OPC_SETALL) begin
            dec.op      = OP_SETALL;
            dec.to_file = 1'b1;
        end
        if (indexed) begin
            // Pointer plus offset; zero pointer lands on low access RAM
            dec.addr = frame_ptr + {4'h0, operand};
        end else if (!insn[ACCESS_BIT]) begin
            // Literal access bank: operands up to 5Fh RAM, above that special registers
            dec.addr = (operand <= OFFSET_MAX) ? {4'h0, operand}
                                               : (ACCESS_HI_BASE | {4'h0, operand});
        end else begin
            dec.addr = {bank_sel, operand};
        end
    end

endmodule

// ### rtl/indexed_literal_offset_exec.sv
`timescale 1ns/1ps

// Function
// - Small access operands become frame-pointer offsets
// - Indexing needs enable, access clear, operand<=5Fh
// - Zero frame pointer maps original access bank
// - Indexed add: working plus byte at offset
// - Destination bit: 0 working, 1 memory
// - Add sets flags; set instructions keep flags
// - Bit set changes only chosen bit
// - Bit set pattern 1000 bbb0 plus offset
// - Set-all-ones writes FFh at offset
// - Set-all-ones pattern 0110 1000 plus offset
// - Extended enable defaults off after reset
module indexed_literal_offset_exec (
    // Clock and synchronous reset
    input  wire logic                CLK,
    input  wire logic                RST,
    // Configuration
    input  wire logic                EXTENDED_SET_ENABLE,
    // Instruction stream
    input  wire logic [15:0]         INSN,
    input  wire logic                INSN_VALID,
    // Addressing context
    input  wire logic [11:0]         STACK_FRAME_POINTER,
    input  wire logic [3:0]          BANK_SELECT,
    // Data memory
    input  wire logic [7:0]          MEM_RDATA,
    output ilo_pkg::mem_req_t        MEM_REQ,
    // Core state
    output logic [7:0]               WORKING,
    output ilo_pkg::flags_t          FLAGS,
    // Handshake
    output logic                     INSN_READY,
    output logic                     INSN_DONE
);
    import ilo_pkg::*;

    // Instruction sequence, one phase per clock:
    //   Decode:  a presented word is matched and its address formed
    //   Read:    the operand byte is taken from the data memory
    //   Process: the result and, for the add, the flags are formed
    //   Write:   the result goes to memory or to the working register
    // The four phases stand in for one instruction cycle of the core,
    // so a new word is accepted every fourth clock at best.
    // Data memory must answer combinationally to the held address;
    // a registered memory would hand back the byte one phase late.
    // There is no forwarding: a write is launched on the edge that returns the
    // sequencer to decode and lands on the next edge, before the next word's read, so the next word always sees fresh data.
    // The frame pointer is sampled only at decode and may change freely
    // while an instruction is in flight.
    // Words that are not one of the three indexed forms are ignored and
    // the sequencer stays in decode; the rest of the instruction set is
    // handled elsewhere in the core.
    // Bit set and set-all-ones never change the working register or flags.

    // Sequencer state
    phase_t     phase_q, phase_d;         // Instruction phase
    decoded_t   dec_now;                  // Decode of the presented word
    decoded_t   dec_q, dec_d;             // Held decode

    // Datapath state of the instruction in flight
    logic [7:0] opnd_q, opnd_d;           // Operand byte read
    logic [7:0] result_q, result_d;       // Processed result

    // Programmer-visible state
    logic [7:0] work_q, work_d;           // Working register
    flags_t     flags_q, flags_d;         // Status flags

    // Memory side and handshake
    // The enable passes through a flop; a change takes effect one edge later
    mem_req_t   req_q, req_d;             // Memory request register
    logic       ext_q, ext_d;             // Captured extended enable
    logic       done_q, done_d;           // Completion pulse

    // Combinational arithmetic
    logic [8:0] sum;                      // Add with carry out
    logic [4:0] nib;                      // Low nibble add
    logic [7:0] bitmask;                  // One-hot bit mask

    // Shared decoder
    // It sees the registered enable, so the enable in force for a word is
    // the one that stood at the edge before that word was taken.
    ilo_decode u_decode (
        .insn      (INSN),
        .ext_en    (ext_q),
        .frame_ptr (STACK_FRAME_POINTER),
        .bank_sel  (BANK_SELECT),
        .dec       (dec_now)
    );

    // New words only accepted in decode phase
    // Ready is combinational from the phase register; a word presented
    // while it is low is not taken, and nothing reports the refusal.
    assign INSN_READY = (phase_q == PH_DECODE);
    // Every other output comes straight from a flop
    assign MEM_REQ    = req_q;
    assign WORKING    = work_q;
    assign FLAGS      = flags_q;
    assign INSN_DONE  = done_q;

    // Arithmetic helpers
    // Formed from registered values only, never from the ports
    always_comb begin
        // Ninth bit of the sum is the carry
        sum     = {1'b0, work_q} + {1'b0, opnd_q};
        // Low-nibble sum gives the digit carry
        nib     = {1'b0, work_q[3:0]} + {1'b0, opnd_q[3:0]};
        // One-hot mask of the bit to set
        bitmask = 8'h01 << dec_q.bitpos;
    end

    // Next-state logic of the instruction sequencer
    // Every register but the captured enable holds unless a phase below says otherwise;
    // the write strobe and the done pulse default low, so each can only ever last one cycle.
    always_comb begin
        phase_d  = phase_q;
        dec_d    = dec_q;
        opnd_d   = opnd_q;
        result_d = result_q;
        work_d   = work_q;
        flags_d  = flags_q;
        req_d    = req_q;
        // Enable is resampled every cycle, in any phase
        ext_d    = EXTENDED_SET_ENABLE;
        done_d   = 1'b0;
        // Strobe defaults low
        req_d.we = 1'b0;
        // Gray-coded phases: one bit flips per step
        case (phase_q)
            PH_DECODE: begin
                // Ignore words that are not one of the indexed forms
                // Pointer and bank are folded into the address here; later
                // changes to them do not disturb the instruction in flight.
                if (INSN_VALID && dec_now.op != OP_NONE) begin
                    // Hold the whole decode; the word may change after this edge
                    dec_d      = dec_now;
                    req_d.addr = dec_now.addr;
                    phase_d    = PH_READ;
                end
            end
            PH_READ: begin
                // Memory answers combinationally to the held address
                // A registered memory would need an extra phase here
                opnd_d  = MEM_RDATA;
                phase_d = PH_PROCESS;
            end
            PH_PROCESS: begin
                case (dec_q.op)
                    OP_ADD: begin
                        result_d       = sum[7:0];
                        // Flags are only touched on this path
                        flags_d.carry  = sum[8];
                        flags_d.dcarry = nib[4];
                        flags_d.zero   = (sum[7:0] == BYTE_ZERO);
                        flags_d.neg    = sum[7];
                        // Like-signed operands giving the other sign overflow
                        flags_d.ovf    = (work_q[7] == opnd_q[7]) && (sum[7] != work_q[7]);
                    end
                    OP_BITSET: begin
                        // Other bits of the byte pass through untouched
                        result_d = opnd_q | bitmask;
                    end
                    default: begin
                        // Only set-all-ones reaches here; operand is unused
                        result_d = ALL_ONES;
                    end
                endcase
                // Result is held a phase so the write sees a settled value
                phase_d = PH_WRITE;
            end
            default: begin
                // Write phase: destination select
                // Bit set and set-all-ones always name memory; only the add
                // may send its sum to the working register.
                if (dec_q.to_file) begin
                    req_d.we    = 1'b1;
                    req_d.wdata = result_q;
                end else begin
                    work_d = result_q;
                end
                // Done rises with the write; ready returns in the same cycle
                done_d  = 1'b1;
                phase_d = PH_DECODE;
            end
        endcase
    end

    // Registers only; enable falls back to off on reset
    // Reset is synchronous; every register returns to a constant, and a
    // word in flight is dropped without a write.
    always_ff @(posedge CLK) begin
        if (RST) begin
            // Sequencer
            phase_q  <= PH_DECODE;
            dec_q    <= '0;
            // Datapath
            opnd_q   <= BYTE_ZERO;
            result_q <= BYTE_ZERO;
            // Visible state
            work_q   <= BYTE_ZERO;
            flags_q  <= '0;
            // Memory side and handshake
            req_q    <= '0;
            ext_q    <= 1'b0;
            done_q   <= 1'b0;
        end else begin
            // Sequencer
            phase_q  <= phase_d;
            dec_q    <= dec_d;
            // Datapath
            opnd_q   <= opnd_d;
            result_q <= result_d;
            // Visible state
            work_q   <= work_d;
            flags_q  <= flags_d;
            // Memory side and handshake
            req_q    <= req_d;
            ext_q    <= ext_d;
            done_q   <= done_d;
        end
    end

endmodule

// ### dv/indexed_literal_offset_exec_asserts.sv
`timescale 1ns/1ps
module indexed_literal_offset_exec_asserts
    import ilo_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        EXTENDED_SET_ENABLE,
    input wire logic [15:0] INSN,
    input wire logic        INSN_VALID,
    input wire logic [11:0] STACK_FRAME_POINTER,
    input wire logic [3:0]  BANK_SELECT,
    input wire logic [7:0]  MEM_RDATA,
    input mem_req_t         MEM_REQ,
    input wire logic [7:0]  WORKING,
    input flags_t           FLAGS,
    input wire logic        INSN_READY,
    input wire logic        INSN_DONE
);
    // Opcode class of the presented word
    wire       is_add = INSN[15:10] == OPC_ADD;
    wire       is_set = INSN[15:8] == OPC_SETALL;
    wire       is_bit = INSN[15:12] == OPC_BITSET;
    logic [2:0] pos_q; // Bit position held from the take edge
    // Capture bit position; the word changes long before the write
    always_ff @(posedge CLK) begin
        if (INSN_VALID && INSN_READY) pos_q <= INSN[11:9];
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_take;
        INSN_VALID && INSN_READY && (is_add || is_set || is_bit);
    endsequence
    // Enable is lagged one edge, so its effect is judged from the edge before
    sequence s_idx;
        $past(EXTENDED_SET_ENABLE) && !$past(RST) && !INSN[8] && INSN[7:0] <= OFFSET_MAX;
    endsequence
    AST_INDEXED: assert property (s_take ##0 s_idx |=>
        MEM_REQ.addr == $past(STACK_FRAME_POINTER) + {4'h0, $past(INSN[7:0])})
        else $error("indexed address wrong");
    AST_LITERAL: assert property (s_take ##0 (!INSN[8] && (!$past(EXTENDED_SET_ENABLE)
        || $past(RST) || INSN[7:0] > OFFSET_MAX)) |=> MEM_REQ.addr ==
        {($past(INSN[7:0]) > OFFSET_MAX) ? 4'hF : 4'h0, $past(INSN[7:0])})
        else $error("literal address wrong");
    AST_BANKED: assert property (s_take ##0 INSN[8] |=>
        MEM_REQ.addr == {$past(BANK_SELECT), $past(INSN[7:0])}) else $error("bank address wrong");
    AST_TIMING: assert property (s_take |=> !INSN_READY [*3] ##1 (INSN_DONE && INSN_READY))
        else $error("instruction timing wrong");
    AST_SETALL: assert property (s_take ##0 is_set |-> ##4 (MEM_REQ.we &&
        MEM_REQ.wdata == ALL_ONES)) else $error("set-all write wrong");
    AST_BITSET: assert property (s_take ##0 is_bit |-> ##4 (MEM_REQ.we &&
        MEM_REQ.wdata[pos_q])) else $error("bit set write wrong");
    AST_KEEP_FLAGS: assert property (s_take ##0 !is_add |=> $stable(FLAGS) [*4])
        else $error("flags changed");
    AST_TO_WORKING: assert property (s_take ##0 (is_add && !INSN[DEST_BIT]) |=>
        !MEM_REQ.we [*4]) else $error("memory written for working destination");
    AST_RESET: assert property (@(posedge CLK) disable iff (1'b0) RST |=> INSN_READY &&
        !INSN_DONE && !MEM_REQ.we && WORKING == BYTE_ZERO && FLAGS == '0) else $error("reset state");
endmodule
bind indexed_literal_offset_exec indexed_literal_offset_exec_asserts u_asserts (.CLK(CLK),
    .RST(RST), .EXTENDED_SET_ENABLE(EXTENDED_SET_ENABLE), .INSN(INSN), .INSN_VALID(INSN_VALID),
    .STACK_FRAME_POINTER(STACK_FRAME_POINTER), .BANK_SELECT(BANK_SELECT), .MEM_RDATA(MEM_RDATA),
    .MEM_REQ(MEM_REQ), .WORKING(WORKING), .FLAGS(FLAGS), .INSN_READY(INSN_READY),
    .INSN_DONE(INSN_DONE));

// ### dv/indexed_literal_offset_exec_tb.sv
`timescale 1ns/1ps
module indexed_literal_offset_exec_tb;
    import ilo_pkg::*;
    logic        clk = 0, rst = 1, ext = 0, vld = 0, a;
    logic [15:0] insn = '0, word;
    logic [11:0] ptr = '0;
    logic [3:0]  bank = '0;
    logic [7:0]  mem [4096], w, ew = '0, k;  // Data memory and model working value
    mem_req_t    req;
    flags_t      flg, ef = '0;               // Model flags start cleared
    logic        rdy, done;
    int          error_cnt = 0, tests_run = 0;
    logic [31:0] rnd = 32'hDABBBBF4;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
    always #5 clk = ~clk;
    // Memory takes writes on the edge after the pulse is launched
    always @(posedge clk) if (req.we) mem[req.addr] <= req.wdata;
    indexed_literal_offset_exec u_indexed_literal_offset_exec (.CLK(clk), .RST(rst),
        .EXTENDED_SET_ENABLE(ext), .INSN(insn), .INSN_VALID(vld), .STACK_FRAME_POINTER(ptr),
        .BANK_SELECT(bank), .MEM_RDATA(mem[req.addr]), .MEM_REQ(req), .WORKING(w), .FLAGS(flg),
        .INSN_READY(rdy), .INSN_DONE(done));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic tally_and_finish();
        if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // One instruction against the model; entered at a falling edge with ready high
    task automatic run(input logic [15:0] wd_in, input logic xe);
        logic [11:0] ea;
        logic [7:0]  m, wd;
        logic        we_e;
        int          s, n;
        ea = wd_in[8] ? {bank, wd_in[7:0]} : (xe && wd_in[7:0] <= 8'h5F) ? ptr + wd_in[7:0]
            : {(wd_in[7:0] > 8'h5F) ? 4'hF : 4'h0, wd_in[7:0]};
        m = mem[ea];
        s = int'(ew) + m;
        wd = wd_in[15:12] == 4'h8 ? m | (8'h01 << wd_in[11:9]) : wd_in[15:8] == 8'h68 ? 8'hFF
            : s[7:0];
        we_e = !(wd_in[15:10] == 6'h09 && !wd_in[9]);
        if (wd_in[15:10] == 6'h09) begin
            ef.neg = s[7];
            ef.ovf = (ew[7] == m[7]) && (s[7] != ew[7]);
            ef.zero = s[7:0] == 0;
            ef.dcarry = int'(ew[3:0]) + m[3:0] > 15;
            ef.carry = s > 255;
        end
        if (!we_e) ew = s[7:0];
        insn = wd_in;
        vld = 1;
        @(negedge clk);
        vld = 0;
        n = 0;
        repeat (8) if (done !== 1'b1) begin
            n++;
            @(negedge clk);
        end
        `CHK(done, 1'b1)
        `CHK(n, 3)
        `CHK(req.addr, ea)
        `CHK(req.we, we_e)
        if (we_e) `CHK(req.wdata, wd)
        `CHK(w, ew)
        `CHK(flg, ef)
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        for (int i = 0; i < 4096; i++) begin
            rnd = lfsr(rnd);
            mem[i] = rnd[7:0];
        end
        repeat (12) @(negedge clk);
        `CHK({rdy, done, w, flg}, {2'b10, 8'h00, 5'h00})
        rst = 0;
        ext = 1;
        run(16'h6810, 1'b0);
        insn = 16'hFFFF;
        vld = 1;
        @(negedge clk);
        vld = 0;
        `CHK(rdy, 1'b1)
        for (int i = 0; i < 48; i++) begin
            rnd = lfsr(rnd);
            ext = rnd[0];
            ptr = (i % 4 == 0) ? 12'h000 : rnd[31:20];
            bank = rnd[19:16];
            @(negedge clk);
            k = (i % 8 == 1) ? 8'h5F : (i % 8 == 2) ? 8'h60 : rnd[15:8];
            a = rnd[1] & rnd[2];
            word = (i % 3 == 0) ? {6'h09, rnd[3], a, k} : (i % 3 == 1) ? {4'h8, rnd[6:4], a, k}
                : {8'h68, k};
            run(word, ext);
        end
        tally_and_finish();
    end
endmodule
